/* core/feo_pkg.sv */
// Constants shared by the field evaluation output logic
package feo_pkg;
    // Sizes of the evaluation and output stages
    localparam int FEO_NCASE = 10;
    localparam int FEO_NOUT = 14;
    localparam int FEO_NREL = 4;
    // Register byte offsets
    localparam logic [7:0] FEO_A_CTRL = 8'h00;
    localparam logic [7:0] FEO_A_NEGATE = 8'h04;
    localparam logic [7:0] FEO_A_COND_EN = 8'h08;
    localparam logic [7:0] FEO_A_MAP_LO = 8'h0c;
    localparam logic [7:0] FEO_A_MAP_HI = 8'h10;
    localparam logic [7:0] FEO_A_OP_AND = 8'h14;
    localparam logic [7:0] FEO_A_ACT_HIGH = 8'h18;
    localparam logic [7:0] FEO_A_FUNC_APP = 8'h1c;
    localparam logic [7:0] FEO_A_FUNC_NR = 8'h20;
    localparam logic [7:0] FEO_A_RST_DLY = 8'h24;
    localparam logic [7:0] FEO_A_RST_IN = 8'h28;
    localparam logic [7:0] FEO_A_RST_SEL = 8'h2c;
    localparam logic [7:0] FEO_A_RST_LVL = 8'h30;
    localparam logic [7:0] FEO_A_DELAY_MS = 8'h34;
    localparam logic [7:0] FEO_A_RESP = 8'h38;
    localparam logic [7:0] FEO_A_IOLINK = 8'h3c;
    localparam logic [7:0] FEO_A_PHASE = 8'h40;
    localparam logic [7:0] FEO_A_DEG_CYC = 8'h44;
    localparam logic [7:0] FEO_A_BASE_LEN = 8'h48;
    localparam logic [7:0] FEO_A_EXT_LEN = 8'h4c;
    localparam logic [7:0] FEO_A_GAIN = 8'h50;
    localparam logic [7:0] FEO_A_STATUS = 8'h54;
    localparam logic [7:0] FEO_A_SPEED = 8'h58;
    localparam logic [7:0] FEO_A_DYN_LEN = 8'h5c;
    localparam logic [7:0] FEO_A_DET = 8'h60;
    // Control register field positions
    localparam int FEO_C_EXT_EN = 0;
    localparam int FEO_C_ENC_EN = 1;
    localparam int FEO_C_SYNC = 2;
    localparam int FEO_C_RELAY_HIGH = 4;
    localparam int FEO_C_EXT_ID = 8;
    // IO link word: enables in low bits, input selects above
    localparam int FEO_IOL_SEL = 10;
    // Synchronisation modes
    localparam logic [1:0] FEO_SYNC_OFF = 2'h0;
    localparam logic [1:0] FEO_SYNC_MAIN = 2'h1;
    localparam logic [1:0] FEO_SYNC_SUB = 2'h2;
    // Heartbeat supervision needs a module id below this
    localparam logic [5:0] FEO_EXT_ID_LIMIT = 6'h3f;
    // Reset values
    localparam logic [13:0] FEO_FUNC_APP_RST = 14'h3fff;
    localparam logic [13:0] FEO_OUTS_RST = 14'h3fff;
    localparam logic [3:0] FEO_RELAY_RST = 4'hf;
    // Timing
    localparam int FEO_CLK_PERIOD_NS = 10;
    localparam int FEO_MS_NS = 1000000;
    localparam int FEO_MS_CYC = FEO_MS_NS / FEO_CLK_PERIOD_NS;
    localparam int FEO_MAX_DELAY_S = 10;
    localparam logic [13:0] FEO_MAX_DELAY_MS = 14'(FEO_MAX_DELAY_S * 1000);
    localparam logic [8:0] FEO_DEG_FULL = 9'h168;
endpackage

/* core/feo_output_logic.sv */
// Field evaluation output stage with AHB-Lite register slave
`timescale 1ns/10ps
module feo_output_logic
    import feo_pkg::*;
#(
    parameter int MS_CYC = FEO_MS_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [9:0] field_hit,
    input wire logic not_ready,
    input wire logic scan_ref,
    input wire logic first_input,
    input wire logic second_input,
    input wire logic third_input_encoder_a,
    input wire logic fourth_input_encoder_b,
    output logic [4:0] out_pins,
    output logic sixth_output,
    output logic [7:0] ext_out,
    output logic ext_heartbeat_en,
    output logic [3:0] relay_close,
    output logic [16:0] dyn_field_len,
    output logic [15:0] enc_speed,
    output logic scan_trigger
);

    // Whole state of the block
    typedef struct packed {
        logic ap_valid;              // Data phase pending
        logic ap_write;              // Pending phase is a write
        logic [7:0] ap_addr;         // Pending register offset
        logic [31:0] rdata;          // Read data for the data phase
        logic [31:0] ctrl;           // Global control
        logic [9:0] negate;          // Per-case negation
        logic [9:0] cond_en;         // Case needs an input condition
        logic [31:0] map_lo;         // Output index of cases 0..7
        logic [7:0] map_hi;          // Output index of cases 8..9
        logic [13:0] op_and;         // 1 = AND combine, 0 = OR
        logic [13:0] act_high;       // 1 = active-high pin
        logic [13:0] func_app;       // Output follows evaluation
        logic [13:0] func_nr;        // Output shows not-ready
        logic [13:0] rst_dly;        // Delayed release
        logic [13:0] rst_in;         // Release by input
        logic [27:0] rst_sel;        // Release input per output
        logic [13:0] rst_lvl;        // Release input level
        logic [13:0] delay_ms;       // Hold delay in ms
        logic [15:0] resp;           // Response time in cycles
        logic [29:0] iolink;         // IO link enables and selects
        logic [8:0] phase;           // Signed phase in degrees
        logic [15:0] deg_cyc;        // Cycles per degree of scan
        logic [15:0] base_len;       // Dynamic field basic length
        logic [15:0] ext_len;        // Largest extension
        logic [15:0] gain;           // Extension per speed unit
        logic [9:0][15:0] resp_cnt;  // Persistence counters
        logic [9:0] det;             // Debounced detections
        logic [13:0] hold;           // Output held after clear
        logic [13:0][13:0] dly_cnt;  // Remaining hold in ms
        logic [16:0] ms_cnt;         // Millisecond prescaler
        logic enc_prev;              // Encoder edge history
        logic [15:0] enc_cnt;        // Pulses in current window
        logic [15:0] speed;          // Pulses in last window
        logic [16:0] dyn_len;        // Current dynamic length
        logic sync_prev;             // Sync input edge history
        logic ph_busy;               // Phase delay running
        logic [24:0] ph_cnt;         // Phase delay remaining
        logic trig;                  // Scan trigger pulse
        logic [13:0] outs;           // Pin levels
        logic [3:0] relay;           // Relay closed
        logic [7:0] ext_q;           // Expansion outputs
        logic hb;                    // Heartbeat supervision on
    } feo_state_t;

    feo_state_t s_reg;
    feo_state_t s_next;

    // Register read mux; unmapped offsets read zero
    function automatic logic [31:0] rd(input logic [7:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        case (a)
            FEO_A_CTRL: d = s_reg.ctrl;
            FEO_A_NEGATE: d = {22'h0, s_reg.negate};
            FEO_A_COND_EN: d = {22'h0, s_reg.cond_en};
            FEO_A_MAP_LO: d = s_reg.map_lo;
            FEO_A_MAP_HI: d = {24'h0, s_reg.map_hi};
            FEO_A_OP_AND: d = {18'h0, s_reg.op_and};
            FEO_A_ACT_HIGH: d = {18'h0, s_reg.act_high};
            FEO_A_FUNC_APP: d = {18'h0, s_reg.func_app};
            FEO_A_FUNC_NR: d = {18'h0, s_reg.func_nr};
            FEO_A_RST_DLY: d = {18'h0, s_reg.rst_dly};
            FEO_A_RST_IN: d = {18'h0, s_reg.rst_in};
            FEO_A_RST_SEL: d = {4'h0, s_reg.rst_sel};
            FEO_A_RST_LVL: d = {18'h0, s_reg.rst_lvl};
            FEO_A_DELAY_MS: d = {18'h0, s_reg.delay_ms};
            FEO_A_RESP: d = {16'h0, s_reg.resp};
            FEO_A_IOLINK: d = {2'h0, s_reg.iolink};
            FEO_A_PHASE: d = {{23{s_reg.phase[8]}}, s_reg.phase};
            FEO_A_DEG_CYC: d = {16'h0, s_reg.deg_cyc};
            FEO_A_BASE_LEN: d = {16'h0, s_reg.base_len};
            FEO_A_EXT_LEN: d = {16'h0, s_reg.ext_len};
            FEO_A_GAIN: d = {16'h0, s_reg.gain};
            FEO_A_STATUS: d = {14'h0, s_reg.relay, s_reg.outs};
            FEO_A_SPEED: d = {16'h0, s_reg.speed};
            FEO_A_DYN_LEN: d = {15'h0, s_reg.dyn_len};
            FEO_A_DET: d = {22'h0, s_reg.det};
            default: d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    // Next-state logic for the bus, cases, outputs, encoder and sync
    always_comb begin
        logic [3:0] ine;
        logic [3:0] code;
        logic [39:0] map;
        logic [3:0] oi;
        logic [13:0] anyv;
        logic [13:0] orv;
        logic [13:0] andv;
        logic [13:0] res;
        logic [1:0] sel;
        logic r;
        logic v;
        logic act;
        logic lv;
        logic tick;
        logic encm;
        logic subm;
        logic mainm;
        logic ref_ev;
        logic [8:0] deg;
        logic [31:0] prod;
        ine = 4'h0;
        code = 4'h0;
        map = 40'h0;
        oi = 4'h0;
        anyv = 14'h0;
        orv = 14'h0;
        andv = 14'h3fff;
        res = 14'h0;
        sel = 2'h0;
        r = 1'b0;
        v = 1'b0;
        act = 1'b0;
        lv = 1'b0;
        tick = 1'b0;
        encm = 1'b0;
        subm = 1'b0;
        mainm = 1'b0;
        ref_ev = 1'b0;
        deg = 9'h000;
        prod = 32'h0000_0000;
        // Every field keeps its value unless a branch below moves it
        s_next = s_reg;
        encm = s_reg.ctrl[FEO_C_ENC_EN];
        mainm = s_reg.ctrl[FEO_C_SYNC+:2] == FEO_SYNC_MAIN;
        subm = s_reg.ctrl[FEO_C_SYNC+:2] == FEO_SYNC_SUB;
        // Encoder use or sync sub mode takes inputs three and four off the logic
        ine[0] = first_input;
        ine[1] = second_input;
        ine[2] = third_input_encoder_a & ~(encm | subm);
        ine[3] = fourth_input_encoder_b & ~(encm | subm);
        // Input one is the most significant bit of the case code
        code = {ine[0], ine[1], ine[2], ine[3]};

        // Millisecond tick shared by hold delays and speed window
        tick = s_reg.ms_cnt == 17'(MS_CYC - 1);
        s_next.ms_cnt = tick ? 17'h0 : s_reg.ms_cnt + 17'h1;

        // Speed is pulses per ms window; direction is not decoded
        s_next.enc_prev = third_input_encoder_a;
        if (tick) begin
            s_next.speed = s_reg.enc_cnt;
            s_next.enc_cnt = 16'h0;
        end else if (encm && third_input_encoder_a && !s_reg.enc_prev) begin
            s_next.enc_cnt = s_reg.enc_cnt + 16'h1;
        end
        // Length grows linearly with speed, capped at the extension
        prod = {16'h0, s_reg.speed} * {16'h0, s_reg.gain};
        if (prod > {16'h0, s_reg.ext_len}) begin
            s_next.dyn_len = {1'b0, s_reg.base_len} + {1'b0, s_reg.ext_len};
        end else begin
            s_next.dyn_len = {1'b0, s_reg.base_len} + {1'b0, prod[15:0]};
        end

        // Scan trigger: reference edge plus phase offset
        s_next.sync_prev = fourth_input_encoder_b;
        ref_ev = subm ? (fourth_input_encoder_b & ~s_reg.sync_prev) : scan_ref;
        // Negative phase wraps to the equivalent positive angle
        deg = s_reg.phase[8] ? s_reg.phase + FEO_DEG_FULL : s_reg.phase;
        s_next.trig = 1'b0;
        if (ref_ev) begin
            s_next.ph_cnt = 25'({16'h0, deg} * {9'h0, s_reg.deg_cyc});
            s_next.ph_busy = 1'b1;
        end else if (s_reg.ph_busy) begin
            if (s_reg.ph_cnt == 25'h0) begin
                s_next.trig = 1'b1;
                s_next.ph_busy = 1'b0;
            end else begin
                s_next.ph_cnt = s_reg.ph_cnt - 25'h1;
            end
        end

        // Per-case persistence, negation and routing
        map = {s_reg.map_hi, s_reg.map_lo};
        for (int i = 0; i < FEO_NCASE; i++) begin
            sel = s_reg.iolink[FEO_IOL_SEL + 2 * i +: 2];
            // An IO link case reads an input instead of a field
            r = s_reg.iolink[i] ? ine[sel] : field_hit[i];
            if (!r) begin
                s_next.resp_cnt[i] = 16'h0;
            end else if (s_reg.resp_cnt[i] < s_reg.resp) begin
                s_next.resp_cnt[i] = s_reg.resp_cnt[i] + 16'h1;
            end
            s_next.det[i] = r & (s_reg.resp_cnt[i] >= s_reg.resp);
            v = s_reg.det[i] ^ s_reg.negate[i];
            act = ~s_reg.cond_en[i] | (code == 4'(i));
            oi = map[4 * i +: 4];
            if (act && oi < 4'(FEO_NOUT)) begin
                anyv[oi] = 1'b1;
                orv[oi] = orv[oi] | v;
                andv[oi] = andv[oi] & v;
            end
        end

        // Per-output combine, hold, function and polarity
        for (int o = 0; o < FEO_NOUT; o++) begin
            res[o] = anyv[o] & (s_reg.op_and[o] ? andv[o] : orv[o]);
            sel = s_reg.rst_sel[2 * o +: 2];
            if (res[o]) begin
                s_next.hold[o] = 1'b1;
                s_next.dly_cnt[o] = s_reg.delay_ms;
            end else if (s_reg.rst_in[o]) begin
                // Release only once the chosen input shows its level
                if (ine[sel] == s_reg.rst_lvl[o]) begin
                    s_next.hold[o] = 1'b0;
                end
            end else if (s_reg.rst_dly[o]) begin
                if (s_reg.dly_cnt[o] == 14'h0) begin
                    s_next.hold[o] = 1'b0;
                end else if (tick) begin
                    s_next.dly_cnt[o] = s_reg.dly_cnt[o] - 14'h1;
                end
            end else begin
                s_next.hold[o] = 1'b0;
            end
            act = res[o] | s_next.hold[o];
            // Not-ready wins over both evaluation and host switching
            lv = s_reg.func_nr[o] ? not_ready : (s_reg.func_app[o] & act);
            s_next.outs[o] = s_reg.act_high[o] ? lv : ~lv;
            if (o < FEO_NREL) begin
                s_next.relay[o] = s_reg.ctrl[FEO_C_RELAY_HIGH + o] ? lv : ~lv;
            end
        end
        // A sync main gives the sixth output over to the sync pulse
        if (mainm) begin
            s_next.outs[5] = scan_ref;
        end
        s_next.ext_q = s_reg.ctrl[FEO_C_EXT_EN] ? s_next.outs[13:6] : 8'h00;
        s_next.hb = s_reg.ctrl[FEO_C_EXT_EN] & (s_reg.ctrl[FEO_C_EXT_ID+:6] < FEO_EXT_ID_LIMIT);

        // Bus data phase: write pending register
        if (s_reg.ap_valid && s_reg.ap_write) begin
            case (s_reg.ap_addr)
                FEO_A_CTRL: s_next.ctrl = hwdata;
                FEO_A_NEGATE: s_next.negate = hwdata[9:0];
                FEO_A_COND_EN: s_next.cond_en = hwdata[9:0];
                FEO_A_MAP_LO: s_next.map_lo = hwdata;
                FEO_A_MAP_HI: s_next.map_hi = hwdata[7:0];
                FEO_A_OP_AND: s_next.op_and = hwdata[13:0];
                FEO_A_ACT_HIGH: s_next.act_high = hwdata[13:0];
                FEO_A_FUNC_APP: s_next.func_app = hwdata[13:0];
                FEO_A_FUNC_NR: s_next.func_nr = hwdata[13:0];
                FEO_A_RST_DLY: s_next.rst_dly = hwdata[13:0];
                FEO_A_RST_IN: s_next.rst_in = hwdata[13:0];
                FEO_A_RST_SEL: s_next.rst_sel = hwdata[27:0];
                FEO_A_RST_LVL: s_next.rst_lvl = hwdata[13:0];
                // Delays beyond the longest hold are clipped
                FEO_A_DELAY_MS: begin
                    s_next.delay_ms = (hwdata[13:0] > FEO_MAX_DELAY_MS) ? FEO_MAX_DELAY_MS : hwdata[13:0];
                end
                FEO_A_RESP: s_next.resp = hwdata[15:0];
                FEO_A_IOLINK: s_next.iolink = hwdata[29:0];
                FEO_A_PHASE: s_next.phase = hwdata[8:0];
                FEO_A_DEG_CYC: s_next.deg_cyc = hwdata[15:0];
                FEO_A_BASE_LEN: s_next.base_len = hwdata[15:0];
                FEO_A_EXT_LEN: s_next.ext_len = hwdata[15:0];
                FEO_A_GAIN: s_next.gain = hwdata[15:0];
                default: begin
                    // Read-only and unmapped offsets ignore writes
                end
            endcase
        end
        // Bus address phase: capture and prepare read data
        if (hsel && htrans[1] && hready) begin
            s_next.ap_valid = 1'b1;
            s_next.ap_write = hwrite;
            s_next.ap_addr = haddr[7:0];
            s_next.rdata = hwrite ? 32'h0000_0000 : rd(haddr[7:0]);
        end else begin
            s_next.ap_valid = 1'b0;
        end
    end

    // State register with synchronous reset and clock enable
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg <= '0;
            s_reg.func_app <= FEO_FUNC_APP_RST;
            s_reg.outs <= FEO_OUTS_RST;
            s_reg.relay <= FEO_RELAY_RST;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    // Outputs; stalling the bus while frozen keeps transfers intact
    assign hreadyout = ce;
    assign hresp = 1'b0;
    assign hrdata = s_reg.rdata;
    assign out_pins = s_reg.outs[4:0];
    assign sixth_output = s_reg.outs[5];
    assign ext_out = s_reg.ext_q;
    assign ext_heartbeat_en = s_reg.hb;
    assign relay_close = s_reg.relay;
    assign dyn_field_len = s_reg.dyn_len;
    assign enc_speed = s_reg.speed;
    assign scan_trigger = s_reg.trig;

endmodule

/* bench/feo_far_end.sv */
// Far-side model: PLC levels on the inputs and an encoder wheel
`timescale 1ns/10ps
module feo_far_end (
    input wire logic clk,
    input wire logic [3:0] lvl,
    input wire logic enc_run,
    output logic first_input,
    output logic second_input,
    output logic third_input_encoder_a,
    output logic fourth_input_encoder_b
);
    logic ph = 1'b0; // Encoder phase, one rise every two cycles
    // Wheel turns freely; gated onto the pin only while running
    always @(posedge clk) begin
        ph <= ~ph;
    end
    // Input code: first input is the most significant bit
    assign first_input = lvl[3];
    assign second_input = lvl[2];
    assign third_input_encoder_a = enc_run ? ph : lvl[1];
    assign fourth_input_encoder_b = lvl[0];
endmodule

/* bench/feo_output_logic_chk.sv */
// Port-level assertions for the field evaluation output stage
`timescale 1ns/10ps
module feo_output_logic_chk
    import feo_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [4:0] out_pins,
    input wire logic sixth_output,
    input wire logic [7:0] ext_out,
    input wire logic ext_heartbeat_en,
    input wire logic [3:0] relay_close,
    input wire logic scan_ref,
    input wire logic scan_trigger
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic ap_wr; // Write address phase taken
    logic [7:0] ap_a; // Its byte address
    logic [31:0] ctrl_sh; // Control word as seen on the bus
    // Shadow the control word so gating can be judged at the pins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ap_wr <= 1'b0;
            ap_a <= 8'h00;
            ctrl_sh <= 32'h0;
        end else if (hready) begin
            ap_wr <= hsel && htrans[1] && hwrite;
            ap_a <= haddr[7:0];
            if (ap_wr && ap_a == FEO_A_CTRL) begin
                ctrl_sh <= hwdata;
            end
        end
    end
    // Main mode held for two samples, clock running
    sequence s_main;
        ctrl_sh[3:2] == FEO_SYNC_MAIN && $past(ctrl_sh[3:2]) == FEO_SYNC_MAIN && $past(ce);
    endsequence
    a_resp_okay: assert property (hresp == 1'b0) else $error("error response");
    a_ready_ce: assert property (hreadyout == ce) else $error("ready not ce");
    a_reset_idle: assert property ($rose(rst_n) |-> out_pins == 5'h1f && relay_close == 4'hf && ext_out == 8'h00)
        else $error("outputs not idle after reset");
    a_freeze_ce: assert property (!ce |=> $stable(out_pins) && $stable(relay_close))
        else $error("outputs moved with ce low");
    a_ext_gated: assert property (!ctrl_sh[0] && !$past(ctrl_sh[0]) |-> ext_out == 8'h00)
        else $error("expansion driven while off");
    a_beat_id: assert property (ext_heartbeat_en |-> $past(ctrl_sh[0]) && $past(ctrl_sh[13:8]) < FEO_EXT_ID_LIMIT)
        else $error("heartbeat with bad id");
    a_trig_pulse: assert property (scan_trigger |=> !scan_trigger) else $error("trigger too long");
    a_sync_main: assert property (s_main |-> sixth_output == $past(scan_ref))
        else $error("sync out not reference");
endmodule

/* bench/feo_output_logic_bench.sv */
// Self-checking bench for the field evaluation output stage
`timescale 1ns/10ps
`define C(x, y) begin compares++; if ((x) !== (y)) begin n_fail++; \
    $display("unexpected at %0t: value mismatch", $time); end end
module feo_output_logic_bench
    import feo_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1; // Run
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2; // Whole words only
    logic [31:0] hwdata = 32'h0;
    logic hready, hreadyout, hresp;
    logic [31:0] hrdata, q;
    logic [9:0] field_hit = 10'h000;
    logic not_ready = 1'b0;
    logic scan_ref = 1'b0;
    logic first_input, second_input, third_input_encoder_a, fourth_input_encoder_b;
    logic [4:0] out_pins;
    logic sixth_output, ext_heartbeat_en, scan_trigger;
    logic [7:0] ext_out;
    logic [3:0] relay_close;
    logic [16:0] dyn_field_len;
    logic [15:0] enc_speed;
    logic [3:0] lvl = 4'h0; // Input levels from the far side
    logic enc_run = 1'b0; // Far side turns its wheel
    int n_fail = 0;
    int compares = 0;
    int n;
    assign hready = hreadyout; // Only slave on the bus
    // Free-running 100 MHz clock
    always #5 clk = ~clk;
    // Short ms tick keeps hold and speed windows cheap
    feo_output_logic #(.MS_CYC(20)) i_dut (.*);
    feo_far_end i_far (.*);
    // One single AHB transfer; read data lands in q
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        q = hrdata;
    endtask
    // Present field hits and let the path settle
    task f(input logic [9:0] h);
        field_hit <= h;
        repeat (4) @(posedge clk);
    endtask
    // Reference pulse, then count cycles to the trigger
    task trig;
        scan_ref <= 1'b1;
        @(posedge clk);
        scan_ref <= 1'b0;
        n = 0;
        while (scan_trigger !== 1'b1 && n < 1000) begin
            @(posedge clk);
            n++;
        end
    endtask
    // Counts and verdict, then stop
    task results;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Watchdog well beyond the few thousand cycles the tests need
    initial begin
        #300000;
        n_fail++;
        results;
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        `C(out_pins, 5'h1f)
        `C(relay_close, 4'hf)
        bus(0, FEO_A_FUNC_APP, 0); `C(q, 32'h3fff)
        bus(0, 8'h80, 0); `C(q, 32'h0)
        bus(1, FEO_A_DELAY_MS, 32'hffff);
        bus(0, FEO_A_DELAY_MS, 0); `C(q, 32'h2710)
        $display("reset test done");
        bus(1, FEO_A_MAP_LO, 32'hffff62f0);
        bus(1, FEO_A_MAP_HI, 32'h0f);
        f(10'h001); `C(out_pins, 5'h1e)
        `C(relay_close, 4'he)
        bus(1, FEO_A_CTRL, 32'h10); f(10'h001); `C(relay_close, 4'hf)
        bus(1, FEO_A_CTRL, 0);
        bus(1, FEO_A_NEGATE, 32'h1); f(10'h001); `C(out_pins[0], 1'b1)
        f(10'h000); `C(out_pins[0], 1'b0)
        bus(1, FEO_A_ACT_HIGH, 32'h1); f(10'h000); `C(out_pins[0], 1'b1)
        bus(1, FEO_A_NEGATE, 0);
        bus(1, FEO_A_ACT_HIGH, 0); f(10'h000); `C(out_pins[0], 1'b1)
        $display("polarity test done");
        f(10'h001); `C(out_pins[0], 1'b0)
        bus(1, FEO_A_OP_AND, 32'h1); f(10'h001); `C(out_pins[0], 1'b1)
        f(10'h201); `C(out_pins[0], 1'b0)
        bus(1, FEO_A_OP_AND, 0);
        bus(1, FEO_A_FUNC_APP, 32'h3ffe); f(10'h001); `C(out_pins[0], 1'b1)
        bus(1, FEO_A_FUNC_NR, 32'h1);
        not_ready <= 1'b1; f(10'h000); `C(out_pins[0], 1'b0)
        not_ready <= 1'b0; f(10'h000); `C(out_pins[0], 1'b1)
        bus(1, FEO_A_FUNC_NR, 0);
        bus(1, FEO_A_FUNC_APP, 32'h3fff);
        $display("combine test done");
        bus(1, FEO_A_RESP, 32'h3); f(10'h000); f(10'h001); `C(out_pins[0], 1'b1)
        f(10'h001); `C(out_pins[0], 1'b0)
        bus(1, FEO_A_RESP, 0); f(10'h000);
        bus(1, FEO_A_RST_DLY, 32'h1);
        bus(1, FEO_A_DELAY_MS, 32'h2);
        f(10'h001); f(10'h000); `C(out_pins[0], 1'b0)
        repeat (60) @(posedge clk); `C(out_pins[0], 1'b1)
        bus(1, FEO_A_RST_DLY, 0);
        bus(1, FEO_A_RST_IN, 32'h1);
        bus(1, FEO_A_RST_LVL, 32'h1);
        f(10'h001); f(10'h000); repeat (30) @(posedge clk); `C(out_pins[0], 1'b0)
        lvl <= 4'h8; f(10'h000); `C(out_pins[0], 1'b1)
        lvl <= 4'h0;
        bus(1, FEO_A_RST_IN, 0);
        $display("release test done");
        bus(1, FEO_A_COND_EN, 32'h200); f(10'h200); `C(out_pins[0], 1'b1)
        lvl <= 4'h9; f(10'h200); `C(out_pins[0], 1'b0)
        lvl <= 4'h0; f(10'h001); `C(out_pins[0], 1'b0)
        bus(1, FEO_A_COND_EN, 0);
        bus(1, FEO_A_IOLINK, 32'h4);
        lvl <= 4'h8; f(10'h000); `C(out_pins[2], 1'b0)
        lvl <= 4'h0; f(10'h000); `C(out_pins[2], 1'b1)
        $display("input test done");
        bus(1, FEO_A_CTRL, 32'h0501); f(10'h000); `C(ext_out, 8'hff)
        `C(ext_heartbeat_en, 1'b1)
        f(10'h008); `C(ext_out, 8'hfe)
        bus(1, FEO_A_CTRL, 32'h3f01); f(10'h000); `C(ext_heartbeat_en, 1'b0)
        bus(1, FEO_A_CTRL, 0); f(10'h000); `C(ext_out, 8'h00)
        bus(1, FEO_A_DEG_CYC, 32'h1);
        bus(1, FEO_A_CTRL, 32'h4);
        bus(1, FEO_A_PHASE, 32'ha); trig; `C(n inside {[9:14]}, 1'b1)
        bus(1, FEO_A_PHASE, 32'h1f6); trig; `C(n inside {[349:354]}, 1'b1)
        // Sub mode: own reference ignored, fourth input rise starts the scan
        bus(1, FEO_A_CTRL, 32'h8);
        bus(1, FEO_A_PHASE, 32'h0); trig; `C(n, 1000)
        lvl <= 4'h1;
        @(posedge clk);
        lvl <= 4'h0;
        repeat (2) @(posedge clk); `C(scan_trigger, 1'b1)
        ce <= 1'b0;
        repeat (5) @(posedge clk);
        ce <= 1'b1;
        bus(1, FEO_A_CTRL, 32'h2);
        $display("sync test done");
        bus(1, FEO_A_GAIN, 32'h1);
        bus(1, FEO_A_BASE_LEN, 32'h64);
        bus(1, FEO_A_EXT_LEN, 32'h3);
        enc_run <= 1'b1; repeat (60) @(posedge clk); `C(dyn_field_len, 17'h67)
        `C(enc_speed inside {16'h9, 16'ha}, 1'b1)
        enc_run <= 1'b0; repeat (60) @(posedge clk); `C(dyn_field_len, 17'h64)
        `C(enc_speed, 16'h0)
        $display("encoder test done");
        results;
    end
endmodule
bind feo_output_logic feo_output_logic_chk i_chk (.*);
